// ---- smcgb_params.svh ----
// Constants for the sleep-mode clock gate bank: offsets, field positions, reset values.
// Assumes a 12-bit byte address inside the system control space and 32-bit register data.
`ifndef SMCGB_PARAMS_SVH
`define SMCGB_PARAMS_SVH

// Byte offsets within the system control register space.
`define SMCGB_RUN_GATE_OFS 12'h104
`define SMCGB_SLEEP_GATE_OFS 12'h114
`define SMCGB_DEEP_GATE_OFS 12'h124
`define SMCGB_CLK_CONFIG_OFS 12'h180
`define SMCGB_IRQ_STATUS_OFS 12'h184
`define SMCGB_IRQ_MASK_OFS 12'h188

// Gate bit positions of the units covered by the bank.
`define SMCGB_ANALOG_CMP_ONE_BIT 25
`define SMCGB_ANALOG_CMP_ZERO_BIT 24
`define SMCGB_GP_COUNTER_HI_BIT 19
`define SMCGB_GP_COUNTER_LO_BIT 16
`define SMCGB_TWO_WIRE_ONE_BIT 14
`define SMCGB_TWO_WIRE_ZERO_BIT 12
`define SMCGB_SYNC_SERIAL_ONE_BIT 5
`define SMCGB_SYNC_SERIAL_ZERO_BIT 4
`define SMCGB_ASYNC_SERIAL_HI_BIT 2
`define SMCGB_ASYNC_SERIAL_LO_BIT 0

// Writable bits of every gate register; all other bits are reserved and read zero.
`define SMCGB_GATE_WMASK 32'h030f_5037

// Reset values.
`define SMCGB_GATE_RESET 32'h0000_0000
`define SMCGB_CONFIG_RESET 1'h0
`define SMCGB_IRQ_RESET 2'h0

// Field positions of the configuration and interrupt registers.
`define SMCGB_AUTO_GATING_BIT 0
`define SMCGB_IRQ_FAULT_BIT 0
`define SMCGB_IRQ_WAKE_BIT 1

`endif

// ---- smcgb_pkg.sv ----
// Types shared by the sleep-mode clock gate bank.
// Assumes nothing of its surroundings; constants live in smcgb_params.svh.
package smcgb_pkg;

   // Power state seen by the gate bank.
   typedef enum logic [1:0] {SMCGB_MODE_RUN, SMCGB_MODE_SLEEP, SMCGB_MODE_DEEP} smcgb_mode_t;

   // Register bus request from the processor side.
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } smcgb_bus_t;

   // Access aimed at a gated unit, identified by its gate bit position.
   typedef struct packed {
      logic valid;
      logic [4:0] unit;
   } smcgb_acc_t;

   // Whole state of the gate bank.
   typedef struct packed {
      smcgb_mode_t mode;
      logic [31:0] run_gate;
      logic [31:0] sleep_gate;
      logic [31:0] deep_gate;
      logic auto_gate;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [31:0] rdata;
      logic [31:0] clk_en;
      logic fault;
      logic done;
      logic irq;
   } smcgb_state_t;

endpackage

// ---- smcgb_gate_bank.sv ----
// Sleep-mode clock gate bank: run, sleep and deep-sleep gate registers and the unit clock enables.
// Assumes the power state inputs and unit access requests come from logic on i_core_clk,
// and that each clock enable drives a latch-based gating cell outside this block.
//
// Summary of operation
// [R01] Sleep with a gate bit set keeps that unit's clock running.
// [R02] A clear gate bit withholds the unit's clock and keeps it disabled.
// [R03] An access to a unit whose clock is off answers with a bus fault.
// [R04] Reset clears every gate bit so all units start unclocked.
// [R05] Separate gate registers exist for running, sleep and deep sleep.
// [R06] Sleep registers apply only while automatic gating is enabled.
// [R07] Analog comparator one and zero gates sit at bits 25 and 24.
// [R08] Counter modules three down to zero gate at bits 19 down to 16.
// [R09] Two-wire module one gates at bit 14, module zero at bit 12.
// [R10] Synchronous serial module one gates at bit 5, module zero at bit 4.
// [R11] Asynchronous serial modules two, one, zero gate at bits 2, 1, 0.
// [R12] Reserved bits read zero; software preserves them on read-modify-write.
// [R13] Software must enable every unit the application needs.
// [R14] The sleep gate register decodes at offset 0x114.
// [R15] Leaving sleep restores run enables cleanly, without a clock glitch.
`timescale 1ns/10ps
`default_nettype none
`include "smcgb_params.svh"

module smcgb_gate_bank (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Register bus.
   input wire smcgb_pkg::smcgb_bus_t i_bus,
   output logic [31:0] o_rdata,
   // Power state from the power controller.
   input wire logic i_sleep,
   input wire logic i_deep_sleep,
   // Accesses aimed at gated units.
   input wire smcgb_pkg::smcgb_acc_t i_acc,
   output logic o_acc_fault,
   output logic o_acc_done,
   // Unit clock enables and interrupt.
   output logic [31:0] o_clk_en,
   output logic o_auto_gating_enable,
   output logic o_irq
);

   smcgb_pkg::smcgb_state_t s_reg;
   smcgb_pkg::smcgb_state_t s_next;
   smcgb_pkg::smcgb_mode_t mode_in;
   logic [31:0] sleep_sel;
   logic [31:0] deep_sel;
   logic [31:0] unit_live;
   logic [31:0] gate_wmask;
   logic fault_evt;
   logic wake_evt;
   logic rst_seen_reg;

   // Only documented gate positions are writable; the rest are reserved.
   assign gate_wmask = `SMCGB_GATE_WMASK; // see [R07] see [R08] see [R09] see [R10] see [R11] see [R12]

   // The power state is decoded every cycle; deep sleep wins over sleep.
   always_comb begin
      if (i_deep_sleep) begin
         mode_in = smcgb_pkg::SMCGB_MODE_DEEP;
      end else if (i_sleep) begin
         mode_in = smcgb_pkg::SMCGB_MODE_SLEEP;
      end else begin
         mode_in = smcgb_pkg::SMCGB_MODE_RUN;
      end
   end

   // Per gate bit, the source of the enable is chosen from the mode and the automatic gating bit.
   // Without automatic gating the run register stays in charge even while the system sleeps.
   for (genvar k = 0; k < 32; k++) begin : g_unit
      assign sleep_sel[k] = s_next.auto_gate && (s_next.mode == smcgb_pkg::SMCGB_MODE_SLEEP); // see [R06]
      assign deep_sel[k] = s_next.auto_gate && (s_next.mode == smcgb_pkg::SMCGB_MODE_DEEP); // see [R06]
      // A unit counts as live only when its enable flop is set and its position is not reserved.
      assign unit_live[k] = s_reg.clk_en[k] & gate_wmask[k]; // see [R02]
   end

   // An access event either completes or faults, judged on the enable the unit sees right now.
   assign fault_evt = i_acc.valid && !unit_live[i_acc.unit]; // see [R03]
   // Leaving either sleep state back to running is reported as a wake event.
   assign wake_evt = (s_reg.mode != smcgb_pkg::SMCGB_MODE_RUN) && (mode_in == smcgb_pkg::SMCGB_MODE_RUN);

   // Next state of the whole bank.
   always_comb begin
      s_next = s_reg;
      s_next.rdata = 32'h0000_0000;
      s_next.fault = 1'b0;
      s_next.done = 1'b0;
      s_next.mode = mode_in;

      // Register writes; reserved bits are dropped so they can never read back nonzero.
      if (i_bus.wr) begin
         unique case (i_bus.addr)
            `SMCGB_RUN_GATE_OFS: begin
               s_next.run_gate = i_bus.wdata & gate_wmask; // see [R05]
            end
            `SMCGB_SLEEP_GATE_OFS: begin
               s_next.sleep_gate = i_bus.wdata & gate_wmask; // see [R14] see [R05]
            end
            `SMCGB_DEEP_GATE_OFS: begin
               s_next.deep_gate = i_bus.wdata & gate_wmask; // see [R05]
            end
            `SMCGB_CLK_CONFIG_OFS: begin
               s_next.auto_gate = i_bus.wdata[`SMCGB_AUTO_GATING_BIT];
            end
            `SMCGB_IRQ_STATUS_OFS: begin
               s_next.irq_stat = s_reg.irq_stat & ~i_bus.wdata[1:0];
            end
            `SMCGB_IRQ_MASK_OFS: begin
               s_next.irq_mask = i_bus.wdata[1:0];
            end
            default: begin
               s_next.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Register reads answer one cycle later; an unmapped address reads zero.
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            `SMCGB_RUN_GATE_OFS: begin
               s_next.rdata = s_reg.run_gate;
            end
            `SMCGB_SLEEP_GATE_OFS: begin
               s_next.rdata = s_reg.sleep_gate; // see [R14] see [R12]
            end
            `SMCGB_DEEP_GATE_OFS: begin
               s_next.rdata = s_reg.deep_gate;
            end
            `SMCGB_CLK_CONFIG_OFS: begin
               s_next.rdata = {31'h0000_0000, s_reg.auto_gate};
            end
            `SMCGB_IRQ_STATUS_OFS: begin
               s_next.rdata = {30'h0000_0000, s_reg.irq_stat};
            end
            `SMCGB_IRQ_MASK_OFS: begin
               s_next.rdata = {30'h0000_0000, s_reg.irq_mask};
            end
            default: begin
               s_next.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Access answer: one cycle after the request, fault or done, never both.
      if (i_acc.valid) begin
         s_next.fault = fault_evt; // see [R03]
         s_next.done = !fault_evt;
      end

      // Events are applied after the software clear so a same-cycle event is never lost.
      if (fault_evt) begin
         s_next.irq_stat[`SMCGB_IRQ_FAULT_BIT] = 1'b1;
      end
      if (wake_evt) begin
         s_next.irq_stat[`SMCGB_IRQ_WAKE_BIT] = 1'b1;
      end

      // The enable register follows the new mode and register values in the same edge,
      // so a write or a mode change reaches the gating cells after exactly one edge.
      // Every enable comes from a flop, which is what keeps the gated clock glitch free.
      s_next.clk_en = deep_sel[0] ? s_next.deep_gate : s_next.run_gate; // see [R05] see [R15]
      if (sleep_sel[0]) begin
         s_next.clk_en = s_next.sleep_gate; // see [R01] see [R02]
      end

      s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
   end

   // All state resets to constants; gate registers start cleared so no unit is clocked.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg.mode <= smcgb_pkg::SMCGB_MODE_RUN;
         s_reg.run_gate <= `SMCGB_GATE_RESET; // see [R04]
         s_reg.sleep_gate <= `SMCGB_GATE_RESET; // see [R04]
         s_reg.deep_gate <= `SMCGB_GATE_RESET; // see [R04]
         s_reg.auto_gate <= `SMCGB_CONFIG_RESET;
         s_reg.irq_stat <= `SMCGB_IRQ_RESET;
         s_reg.irq_mask <= `SMCGB_IRQ_RESET;
         s_reg.rdata <= 32'h0000_0000;
         s_reg.clk_en <= `SMCGB_GATE_RESET; // see [R04]
         s_reg.fault <= 1'b0;
         s_reg.done <= 1'b0;
         s_reg.irq <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs come straight from the state flops.
   assign o_rdata = s_reg.rdata;
   assign o_acc_fault = s_reg.fault;
   assign o_acc_done = s_reg.done;
   assign o_clk_en = s_reg.clk_en;
   assign o_auto_gating_enable = s_reg.auto_gate;
   assign o_irq = s_reg.irq;

   // Marks the cycles after the first edge that follows reset release; only assertions read it.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_seen_reg <= 1'b0;
      end else begin
         rst_seen_reg <= 1'b1;
      end
   end

   // Right after reset every gate register and enable reads as cleared.
   reset_clear_a: assert property ( // see [R04]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !rst_seen_reg |-> (s_reg.sleep_gate == 32'h0000_0000) && (o_clk_en == 32'h0000_0000)
         && (s_reg.run_gate == 32'h0000_0000) && (s_reg.deep_gate == 32'h0000_0000))
      else $error("Gate registers not clear after reset.");

   // In sleep with automatic gating the sleep register drives the enables.
   sleep_enable_a: assert property ( // see [R01]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s_reg.mode == smcgb_pkg::SMCGB_MODE_SLEEP) && s_reg.auto_gate |-> o_clk_en == s_reg.sleep_gate)
      else $error("Sleep enables do not follow the sleep gate register.");

   // A unit clock never runs unless some gate register holds its bit.
   gated_off_a: assert property ( // see [R02]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_clk_en & ~(s_reg.run_gate | s_reg.sleep_gate | s_reg.deep_gate)) == 32'h0000_0000)
      else $error("Unit clock enabled without any gate bit.");

   // An access to an unclocked unit faults in the next cycle and does not complete.
   fault_resp_a: assert property ( // see [R03]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc.valid && !o_clk_en[i_acc.unit] |=> o_acc_fault && !o_acc_done ##1 (!o_acc_fault || $past(i_acc.valid)))
      else $error("Access to an unclocked unit did not fault.");

   // An access to a clocked unit completes without fault.
   done_resp_a: assert property ( // see [R03]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc.valid && o_clk_en[i_acc.unit] && gate_wmask[i_acc.unit] |=> o_acc_done && !o_acc_fault)
      else $error("Access to a clocked unit did not complete.");

   // In deep sleep with automatic gating the deep register drives the enables.
   deep_select_a: assert property ( // see [R05]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s_reg.mode == smcgb_pkg::SMCGB_MODE_DEEP) && s_reg.auto_gate |-> o_clk_en == s_reg.deep_gate)
      else $error("Deep sleep enables do not follow the deep gate register.");

   // Without automatic gating the run register governs in every mode.
   auto_gate_off_a: assert property ( // see [R06]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !s_reg.auto_gate |-> o_clk_en == s_reg.run_gate)
      else $error("Sleep register applied while automatic gating is off.");

   // Only the documented positions can ever be set in the sleep register.
   field_layout_a: assert property ( // see [R07] see [R08] see [R09] see [R10] see [R11]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_bus.wr && (i_bus.addr == `SMCGB_SLEEP_GATE_OFS) && (i_bus.wdata == 32'hffff_ffff)
      |=> s_reg.sleep_gate == 32'h030f_5037)
      else $error("Sleep gate field layout is wrong.");

   // Reads of the sleep register return zero in every reserved position.
   reserved_zero_a: assert property ( // see [R12]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_bus.rd && (i_bus.addr == `SMCGB_SLEEP_GATE_OFS) |=> (o_rdata & ~gate_wmask) == 32'h0000_0000)
      else $error("Reserved sleep gate bits read nonzero.");

   // A write at the sleep offset reads back at the same offset.
   sleep_readback_a: assert property ( // see [R14]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_bus.wr && (i_bus.addr == `SMCGB_SLEEP_GATE_OFS) ##1 i_bus.rd && !i_bus.wr
         && (i_bus.addr == `SMCGB_SLEEP_GATE_OFS)
      |=> o_rdata == ($past(i_bus.wdata, 2) & gate_wmask))
      else $error("Sleep gate register does not read back its write.");

   // On return to running the enables equal the run register at once.
   wake_restore_a: assert property ( // see [R15]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      ($past(s_reg.mode) != smcgb_pkg::SMCGB_MODE_RUN) && (s_reg.mode == smcgb_pkg::SMCGB_MODE_RUN)
      |-> (o_clk_en == s_reg.run_gate) && s_reg.irq_stat[`SMCGB_IRQ_WAKE_BIT])
      else $error("Run enables not restored on leaving sleep.");

   // A fault sets its sticky bit even when software clears it in the same cycle.
   fault_sticky_a: assert property ( // see [R03]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      fault_evt |=> s_reg.irq_stat[`SMCGB_IRQ_FAULT_BIT] && o_acc_fault)
      else $error("Fault event lost from the status register.");

   // An access is answered by a fault or a completion, never by both at once.
   resp_exclusive_a: assert property ( // see [R03]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !(o_acc_fault && o_acc_done))
      else $error("Access answered with fault and completion together.");

   // With no access in a cycle there is no answer in the next one.
   resp_pulse_a: assert property ( // see [R03]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !i_acc.valid |=> !o_acc_fault && !o_acc_done)
      else $error("Access answer without a request.");

   // Reserved positions never carry a clock enable, whatever the registers hold.
   reserved_enable_a: assert property ( // see [R12]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_clk_en & ~`SMCGB_GATE_WMASK) == 32'h0000_0000)
      else $error("Clock enable set in a reserved position.");

   // While running, the run register alone drives the enables.
   run_select_a: assert property ( // see [R15]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (s_reg.mode == smcgb_pkg::SMCGB_MODE_RUN) |-> o_clk_en == s_reg.run_gate)
      else $error("Run enables do not follow the run gate register.");

   // A return to running is remembered in the wake status bit.
   wake_sticky_a: assert property ( // see [R15]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      wake_evt |=> s_reg.irq_stat[`SMCGB_IRQ_WAKE_BIT] && (s_reg.mode == smcgb_pkg::SMCGB_MODE_RUN))
      else $error("Wake event lost from the status register.");

   // A write at the sleep offset lands with reserved bits dropped.
   sleep_write_a: assert property ( // see [R14]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_bus.wr && (i_bus.addr == `SMCGB_SLEEP_GATE_OFS) |=> s_reg.sleep_gate == ($past(i_bus.wdata) & `SMCGB_GATE_WMASK))
      else $error("Sleep gate write did not land.");

   // A write to any other offset leaves the sleep register alone.
   sleep_decode_a: assert property ( // see [R14]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_bus.wr && (i_bus.addr != `SMCGB_SLEEP_GATE_OFS) |=> $stable(s_reg.sleep_gate))
      else $error("Sleep gate register changed by a write elsewhere.");

   // The automatic gating bit follows a configuration write one edge later.
   config_write_a: assert property ( // see [R06]
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_bus.wr && (i_bus.addr == `SMCGB_CLK_CONFIG_OFS) |=> o_auto_gating_enable == $past(i_bus.wdata[0]))
      else $error("Automatic gating bit does not follow its write.");

   // Read data stand only in the cycle after a read strobe and are zero otherwise.
   rdata_idle_a: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !i_bus.rd |=> o_rdata == 32'h0000_0000)
      else $error("Read data present without a read.");

   // Writing a one to the fault status bit clears it when no new fault arrives.
   status_clear_a: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_bus.wr && (i_bus.addr == `SMCGB_IRQ_STATUS_OFS) && i_bus.wdata[`SMCGB_IRQ_FAULT_BIT] && !fault_evt
      |=> !s_reg.irq_stat[`SMCGB_IRQ_FAULT_BIT])
      else $error("Fault status bit not cleared by its write.");

   // The interrupt level always matches the masked status it was built from.
   irq_level_a: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_irq == |(s_reg.irq_stat & s_reg.irq_mask))
      else $error("Interrupt level disagrees with masked status.");

endmodule

`default_nettype wire

// ---- smcgb_dummy_guard.sv ----
// Holds no logic; kept empty so the file list stays in compile order.
// Assumes nothing.

// ---- smcgb_unit_model.sv ----
// Model of the gated peripheral units: each bench request becomes one access toward the gate bank.
// Assumes the bench drives requests on i_core_clk and the gate bank answers one cycle after the access.
`timescale 1ns/10ps
`default_nettype none

module smcgb_unit_model (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Request from the bench.
   input wire logic i_go,
   input wire logic [4:0] i_unit,
   // Access toward the gate bank.
   output var smcgb_pkg::smcgb_acc_t o_acc
);
   // Accesses are one-cycle pulses.
   // The idle unit field toggles so that a stale number can never pass for a real request.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_acc <= '0;
      end else begin
         o_acc.valid <= i_go;
         o_acc.unit <= i_go ? i_unit : ~o_acc.unit;
      end
   end
endmodule

`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the sleep-mode clock gate bank: register bus, power modes, unit access, interrupt.
// Assumes smcgb_pkg, smcgb_gate_bank and smcgb_unit_model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module testbench;
   localparam logic [11:0] a_run = 12'h104;
   localparam logic [11:0] a_slp = 12'h114;
   localparam logic [11:0] a_dsl = 12'h124;
   localparam logic [11:0] a_cfg = 12'h180;
   localparam logic [11:0] a_sts = 12'h184;
   localparam logic [11:0] a_msk = 12'h188;
   localparam logic [11:0] a_bad = 12'h100;
   logic clk, rst_n, sleep, deep, go, fault, done, auto_en, irq;
   logic [4:0] unit;
   logic [31:0] rdata, clk_en, wmask;
   smcgb_pkg::smcgb_bus_t bus;
   smcgb_pkg::smcgb_acc_t acc;
   int n_errors, samples_checked;
   int pos[13] = '{25, 24, 19, 18, 17, 16, 14, 12, 5, 4, 2, 1, 0};

   smcgb_gate_bank smcgb_gate_bank_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .o_rdata(rdata),
      .i_sleep(sleep), .i_deep_sleep(deep), .i_acc(acc), .o_acc_fault(fault), .o_acc_done(done),
      .o_clk_en(clk_en), .o_auto_gating_enable(auto_en), .o_irq(irq));
   smcgb_unit_model smcgb_unit_model_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_unit(unit),
      .o_acc(acc));

   // Free-running 250 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Case equality so that an unknown never counts as a match.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle write strobe.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // One-cycle read strobe; the data stand only in the following cycle, so they are sampled there.
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk("read data", exp, rdata);
   endtask

   // Sets the power state; enables follow at the same edge that samples it.
   task automatic mode(input logic s, input logic d, input logic [31:0] exp);
      @(posedge clk);
      sleep <= s;
      deep <= d;
      repeat (2) @(posedge clk);
      #1 chk("clock enables", exp, clk_en);
   endtask

   // The model raises the access one edge after the request; the answer follows the next edge.
   task automatic access(input logic [4:0] u, input logic f);
      @(posedge clk);
      go <= 1'b1;
      unit <= u;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1 chk("access fault", {31'h0, f}, {31'h0, fault});
      chk("access done", {31'h0, ~f}, {31'h0, done});
   endtask

   // The interrupt level changes at the same edge as status and mask.
   task automatic irq_is(input logic v);
      @(posedge clk);
      #1 chk("interrupt", {31'h0, v}, {31'h0, irq});
   endtask

   // Watchdog against a hung run.
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      results();
   end

   initial begin
      rst_n = 1'b0;
      {sleep, deep, go} = 3'h0;
      unit = 5'h00;
      bus = '0;
      n_errors = 0;
      samples_checked = 0;
      wmask = 32'h0000_0000;
      foreach (pos[k]) wmask[pos[k]] = 1'b1;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk("clock enables", 32'h0000_0000, clk_en);
      rd(a_run, 32'h0000_0000);
      rd(a_slp, 32'h0000_0000);
      rd(a_dsl, 32'h0000_0000);
      rd(a_cfg, 32'h0000_0000);
      $display("test reset done");
      // Walking one through every position, then all ones.
      for (int b = 0; b < 32; b++) begin
         wr(a_slp, 32'h0000_0001 << b);
         rd(a_slp, (32'h0000_0001 << b) & wmask);
      end
      wr(a_slp, 32'hffff_ffff);
      rd(a_slp, wmask);
      wr(a_bad, 32'hffff_ffff);
      rd(a_bad, 32'h0000_0000);
      // Write and read strobes back to back, with no idle cycle between them.
      @(posedge clk);
      bus <= '{addr: a_slp, wdata: 32'h0000_1010, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '{addr: a_slp, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk("read data", 32'h0000_1010, rdata);
      wr(a_run, 32'h0000_0037);
      wr(a_slp, 32'h030f_0000);
      wr(a_dsl, 32'h0000_5000);
      rd(a_run, 32'h0000_0037);
      rd(a_dsl, 32'h0000_5000);
      $display("test fields done");
      mode(1'b1, 1'b0, 32'h0000_0037);
      wr(a_cfg, 32'h0000_0001);
      #1 chk("auto gating", 32'h0000_0001, {31'h0, auto_en});
      mode(1'b0, 1'b0, 32'h0000_0037);
      mode(1'b1, 1'b0, 32'h030f_0000);
      mode(1'b1, 1'b1, 32'h0000_5000);
      mode(1'b0, 1'b0, 32'h0000_0037);
      rd(a_sts, 32'h0000_0002);
      $display("test modes done");
      access(5'd0, 1'b0);
      access(5'd24, 1'b1);
      access(5'd3, 1'b1);
      mode(1'b1, 1'b0, 32'h030f_0000);
      access(5'd24, 1'b0);
      access(5'd0, 1'b1);
      mode(1'b0, 1'b0, 32'h0000_0037);
      $display("test access done");
      rd(a_sts, 32'h0000_0003);
      wr(a_sts, 32'h0000_0003);
      rd(a_sts, 32'h0000_0000);
      wr(a_msk, 32'h0000_0001);
      rd(a_msk, 32'h0000_0001);
      irq_is(1'b0);
      access(5'd12, 1'b1);
      irq_is(1'b1);
      wr(a_msk, 32'h0000_0002);
      irq_is(1'b0);
      wr(a_msk, 32'h0000_0001);
      irq_is(1'b1);
      wr(a_sts, 32'h0000_0001);
      irq_is(1'b0);
      $display("test interrupt done");
      // A reset in mid-run must clear registers that hold nonzero values.
      wr(a_slp, 32'h030f_5037);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk("clock enables", 32'h0000_0000, clk_en);
      rd(a_run, 32'h0000_0000);
      rd(a_slp, 32'h0000_0000);
      $display("test second reset done");
      results();
   end
endmodule

`default_nettype wire
